// File: inc/result_seq_pkg.sv
// package: constants and carriers for the search result output sequencer
`default_nettype none
package result_seq_pkg;
    // ========================================
    // source-select addresses
    localparam logic [7:0] SRC_HIT_STATUS = 8'h90;
    localparam logic [7:0] SRC_HIT_ADDR   = 8'h94;
    localparam logic [7:0] SRC_CONTENTS   = 8'h0e;
    localparam logic [7:0] SRC_COMBINED   = 8'hb0;
    localparam logic [7:0] SRC_KEY_BASE   = 8'ha0;
    localparam logic [7:0] SRC_KEY_LAST   = 8'hae;
    // ========================================
    // step control field positions (16-bit register)
    localparam int STEP_SRC_LSB  = 0;
    localparam int STEP_MIX_LSB  = 8;
    localparam int STEP_ONE_BIT  = 10;
    localparam int STEP_END_BIT  = 11;
    // sub-step control field positions
    localparam int SUB_SEG_LSB   = 0;
    localparam int SUB_MIX_LSB   = 8;
    localparam int SUB_END_BIT   = 11;
    // ========================================
    // mix code bit positions on the result bus
    localparam int MIX_STAT_LSB  = 28;
    localparam int MIX_OCH_LSB   = 25;
    localparam int MIX_ICH_LSB   = 22;
    // ========================================
    // reset values and result buffer size
    localparam logic [2:0]  PTR_RESET  = 3'h0;
    localparam logic [31:0] BUS_RESET  = 32'h0000_0000;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 32;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_MAIN = 2'b01,
        PH_SUB  = 2'b10,
        PH_DONE = 2'b11
    } phase_t;

    typedef struct packed {
        logic [3:0] hit;  // system hit, system multi, device hit, device multi
        logic [2:0] och;
        logic [2:0] ich;
    } status_bits_t;

    typedef struct packed {
        logic        we;
        logic        sub;  // 1 selects sub-step control
        logic [2:0]  idx;
        logic [15:0] data;
    } cfg_wr_t;
endpackage : result_seq_pkg
`default_nettype wire

// File: rtl/result_fifo.sv
// module: parameterised flip-flop fifo with valid/ready on both sides
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             sys_clk_i,  // clock
    input  wire logic             rst_i,      // async reset
    input  wire logic             ce_i,       // clock enable
    input  wire logic [WIDTH-1:0] in_data_i,  // write data
    input  wire logic             in_valid_i, // write valid
    output logic                  in_ready_o, // not full
    output logic [WIDTH-1:0]      out_data_o, // head data
    output logic                  out_valid_o,// not empty
    input  wire logic             out_ready_i // consumer ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fifo_st_t;
    fifo_st_t st, next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;
    logic full, empty;

    assign empty = (st.wp == st.rp);
    assign full  = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem[st.rp[AW-1:0]];
    assign push = in_valid_i && !full;
    assign pop  = out_ready_i && !empty;

    always_comb begin
        next_st = st;
        if (push) next_st.wp = st.wp + 1'b1;
        if (pop)  next_st.rp = st.rp + 1'b1;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (ce_i && push) begin
            mem[st.wp[AW-1:0]] <= in_data_i;
        end
    end
endmodule : result_fifo
`default_nettype wire

// File: rtl/search_result_output_sequencer.sv
// module: output-port step sequencer placing search results on the result bus
`default_nettype none
module search_result_output_sequencer (
    input  wire logic         sys_clk_i,     // 40 MHz clock
    input  wire logic         rst_i,         // async reset, active high
    input  wire logic         ce_i,          // clock enable
    input  wire logic         rd_n_i,        // read strobe pin, active low
    input  wire logic         ptr_rst_i,     // sequence pointer reset pulse
    input  wire logic         chan_sel_i,    // active channel (0=a, 1=b)
    input  wire logic [2:0]   start_seq_i,   // start sequence number
    input  wire logic [2:0]   start_sub_i,   // start sub-sequence number
    input  wire result_seq_pkg::cfg_wr_t cfg_i, // processor config write
    input  wire logic         cfg_rd_sub_i,  // read selects sub-step bank
    input  wire logic [2:0]   cfg_rd_idx_i,  // read index
    output logic [15:0]       cfg_rd_data_o, // unselected channel readback
    input  wire logic [15:0]  hit_addr_i,    // current highest hit address
    input  wire logic         more_hits_i,   // another hit after current
    input  wire logic         any_hit_i,     // at least one hit
    input  wire logic [31:0]  contents_i,    // segment data of current hit
    input  wire logic [31:0]  key_i,         // selected search key word
    input  wire logic [31:0]  hit_status_i,  // hit status word
    input  wire result_seq_pkg::status_bits_t status_i, // overlay bits
    output logic [2:0]        key_sel_o,     // which key word is wanted
    output logic [2:0]        segment_o,     // segment of current sub-step
    output logic              next_hit_o,    // pulse: step to next hit
    output logic              hit_out_n_o,   // hit pin, active low
    output logic              multi_hit_out_n_o, // multi-hit pin, active low
    output logic [2:0]        seq_ptr_o,     // sequence pointer
    output logic              seq_done_o,    // sequence ended
    output logic [31:0]       result_bus_o,  // result word
    output logic              result_valid_o,// result word valid
    input  wire logic         result_ready_i // consumer ready
);
    // ========================================
    // state
    typedef struct packed {
        logic [2:0]             sync;      // strobe synchroniser, [0] first
        logic                   rd_lvl;    // filtered strobe level
        result_seq_pkg::phase_t phase;     // where the sequencer stands
        logic [2:0]             seq_ptr;   // step pointer
        logic [2:0]             sub_ptr;   // sub-step pointer
        logic [2:0]             start_sub; // sub-step to wrap back to
        logic                   act_chan;  // channel that runs
        logic                   next_hit;  // one-cycle hit advance pulse
        logic                   hit_n;     // hit pin level
        logic                   multi_n;   // multi-hit pin level
        logic [15:0]            rd_data;   // processor readback
        logic [1:0][7:0][15:0]  step_cfg;  // step control, per channel
        logic [1:0][7:0][15:0]  sub_cfg;   // sub-step control, per channel
    } seq_state_t;

    // strobe idles high, so the filter starts high: no false edge at reset
    localparam seq_state_t ST_RESET = '{
        sync:      3'h7,
        rd_lvl:    1'b1,
        phase:     result_seq_pkg::PH_IDLE,
        seq_ptr:   result_seq_pkg::PTR_RESET,
        sub_ptr:   result_seq_pkg::PTR_RESET,
        start_sub: result_seq_pkg::PTR_RESET,
        act_chan:  1'b0,
        next_hit:  1'b0,
        hit_n:     1'b1,
        multi_n:   1'b1,
        rd_data:   16'h0000,
        step_cfg:  '0,
        sub_cfg:   '0
    };

    seq_state_t  st;
    seq_state_t  next_st;
    logic [15:0] cur_step;
    logic [15:0] cur_sub;
    logic [7:0]  src;
    logic [1:0]  step_mix;
    logic        one_flag;
    logic        seq_end;
    logic [2:0]  seg_sel;
    logic [1:0]  sub_mix;
    logic        sub_end;
    logic        is_key;
    logic        rd_fall;
    logic        sub_now;
    logic        step_done;
    logic        end_seen;
    logic        push;
    logic [31:0] push_word;
    logic        fifo_ready;

    // ========================================
    // status overlay on the upper ten result bits
    function automatic logic [31:0] mix_word(
        input logic [31:0]                  w,
        input logic [1:0]                   code,
        input result_seq_pkg::status_bits_t s
    );
        logic [31:0] r;
        r = w;
        if (code[1]) begin
            r[result_seq_pkg::MIX_STAT_LSB +: 4] = s.hit;
        end
        if (code[0]) begin
            r[result_seq_pkg::MIX_OCH_LSB +: 3] = s.och;
            r[result_seq_pkg::MIX_ICH_LSB +: 3] = s.ich;
        end
        return r;
    endfunction : mix_word

    // ========================================
    // decode of the current step and sub-step
    assign cur_step = st.step_cfg[st.act_chan][st.seq_ptr];
    assign cur_sub  = st.sub_cfg[st.act_chan][st.sub_ptr];
    assign src      = cur_step[result_seq_pkg::STEP_SRC_LSB +: 8];
    assign step_mix = cur_step[result_seq_pkg::STEP_MIX_LSB +: 2];
    assign one_flag = cur_step[result_seq_pkg::STEP_ONE_BIT];
    assign seq_end  = cur_step[result_seq_pkg::STEP_END_BIT];
    assign seg_sel  = cur_sub[result_seq_pkg::SUB_SEG_LSB +: 3];
    assign sub_mix  = cur_sub[result_seq_pkg::SUB_MIX_LSB +: 2];
    assign sub_end  = cur_sub[result_seq_pkg::SUB_END_BIT];
    assign is_key   = (src >= result_seq_pkg::SRC_KEY_BASE)
                      && (src <= result_seq_pkg::SRC_KEY_LAST)
                      && !src[0];

    // a falling strobe counts once, when the two late flops agree low
    assign rd_fall = st.rd_lvl
                     && (st.sync[1] == st.sync[2])
                     && !st.sync[2];

    // contents steps run inside the sub-sequence from their first strobe
    always_comb begin
        case (st.phase)
            result_seq_pkg::PH_IDLE,
            result_seq_pkg::PH_MAIN: begin
                sub_now = (src == result_seq_pkg::SRC_CONTENTS);
            end
            result_seq_pkg::PH_SUB: begin
                sub_now = 1'b1;
            end
            result_seq_pkg::PH_DONE: begin
                sub_now = 1'b0;
            end
            default: begin
                sub_now = 1'b0;
            end
        endcase
    end

    // ========================================
    // next state
    always_comb begin
        next_st          = st;
        next_st.next_hit = 1'b0;
        push             = 1'b0;
        push_word        = result_seq_pkg::BUS_RESET;
        step_done        = 1'b0;
        end_seen         = 1'b0;
        next_st.sync[0]  = rd_n_i;
        next_st.sync[1]  = st.sync[0];
        next_st.sync[2]  = st.sync[1];
        if (st.sync[1] == st.sync[2]) begin
            next_st.rd_lvl = st.sync[2];
        end
        // the idle channel can be set up while the other one runs
        if (cfg_i.we) begin
            if (cfg_i.sub) begin
                next_st.sub_cfg[!st.act_chan][cfg_i.idx] = cfg_i.data;
            end else begin
                next_st.step_cfg[!st.act_chan][cfg_i.idx] = cfg_i.data;
            end
        end
        if (cfg_rd_sub_i) begin
            next_st.rd_data = st.sub_cfg[!st.act_chan][cfg_rd_idx_i];
        end else begin
            next_st.rd_data = st.step_cfg[!st.act_chan][cfg_rd_idx_i];
        end
        if (ptr_rst_i) begin
            next_st.seq_ptr   = start_seq_i;
            next_st.sub_ptr   = start_sub_i;
            next_st.start_sub = start_sub_i;
            next_st.act_chan  = chan_sel_i;
            next_st.phase     = result_seq_pkg::PH_IDLE;
            next_st.hit_n     = !any_hit_i;
            next_st.multi_n   = !(any_hit_i && more_hits_i);
        end else if (rd_fall
                     && st.phase != result_seq_pkg::PH_DONE) begin
            if (sub_now) begin
                // segment word of the current hit entry
                push          = 1'b1;
                push_word     = mix_word(contents_i, sub_mix, status_i);
                next_st.phase = result_seq_pkg::PH_SUB;
                if (sub_end) begin
                    next_st.next_hit = 1'b1;
                    next_st.hit_n    = !more_hits_i;
                    if (!more_hits_i) begin
                        next_st.multi_n = 1'b1;
                    end
                    if (one_flag || !more_hits_i) begin
                        step_done = 1'b1;
                    end else begin
                        // next entry: combined steps give its address first
                        next_st.sub_ptr = st.start_sub;
                        next_st.phase   = result_seq_pkg::PH_MAIN;
                    end
                end else begin
                    next_st.sub_ptr = st.sub_ptr + 3'h1;
                end
            end else if (src == result_seq_pkg::SRC_COMBINED) begin
                push          = 1'b1;
                push_word     = mix_word({16'h0000, hit_addr_i},
                                         step_mix, status_i);
                next_st.phase = result_seq_pkg::PH_SUB;
            end else if (src == result_seq_pkg::SRC_HIT_ADDR) begin
                push             = 1'b1;
                push_word        = mix_word({16'h0000, hit_addr_i},
                                            step_mix, status_i);
                next_st.next_hit = 1'b1;
                next_st.hit_n    = !more_hits_i;
                if (!more_hits_i) begin
                    next_st.multi_n = 1'b1;
                end
                if (one_flag || !more_hits_i) begin
                    step_done = 1'b1;
                end
            end else if (src == result_seq_pkg::SRC_HIT_STATUS) begin
                // status is never mixed into itself
                push      = 1'b1;
                push_word = hit_status_i;
                step_done = 1'b1;
            end else if (is_key) begin
                push      = 1'b1;
                push_word = mix_word(key_i, step_mix, status_i);
                step_done = 1'b1;
            end else begin
                // unknown source: only the overlay, if any, is shown
                push      = 1'b1;
                push_word = mix_word(result_seq_pkg::BUS_RESET,
                                     step_mix, status_i);
                step_done = 1'b1;
            end
        end
        // ending needs both end flags, so an unset sub end never stops
        if (step_done) begin
            end_seen = seq_end
                       && st.sub_cfg[st.act_chan][next_st.sub_ptr]
                                    [result_seq_pkg::SUB_END_BIT];
            if (end_seen) begin
                next_st.phase = result_seq_pkg::PH_DONE;
            end else begin
                next_st.seq_ptr = st.seq_ptr + 3'h1;
                next_st.phase   = result_seq_pkg::PH_MAIN;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= ST_RESET;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // ========================================
    // result buffer
    // a consumer that stalls for 32 words loses later words
    result_fifo #(
        .WIDTH (result_seq_pkg::FIFO_WIDTH),
        .DEPTH (result_seq_pkg::FIFO_DEPTH)
    ) out_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_data_i   (push_word),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .out_data_o  (result_bus_o),
        .out_valid_o (result_valid_o),
        .out_ready_i (result_ready_i)
    );

    // ========================================
    // outputs
    assign key_sel_o         = src[3:1];
    assign segment_o         = seg_sel;
    assign next_hit_o        = st.next_hit;
    assign hit_out_n_o       = st.hit_n;
    assign multi_hit_out_n_o = st.multi_n;
    assign seq_ptr_o         = st.seq_ptr;
    assign seq_done_o        = (st.phase == result_seq_pkg::PH_DONE);
    assign cfg_rd_data_o     = st.rd_data;

    // ========================================
    // checks
    sequence s_strobe_taken;
        ce_i && rd_fall && !ptr_rst_i
            && (st.phase != result_seq_pkg::PH_DONE);
    endsequence

    sequence s_quiet;
        ce_i && !rd_fall && !ptr_rst_i;
    endsequence

    a_step_one: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        s_strobe_taken |=> (st.seq_ptr == $past(st.seq_ptr))
            || (st.seq_ptr == $past(st.seq_ptr) + 3'h1))
        else $error("step pointer moved by more than one");

    a_quiet_hold: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        s_quiet |=> $stable(st.seq_ptr) && $stable(st.sub_ptr))
        else $error("pointer moved without a strobe");

    a_done_hold: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ce_i && !ptr_rst_i && st.phase == result_seq_pkg::PH_DONE)
            |=> (st.phase == result_seq_pkg::PH_DONE))
        else $error("ended sequence restarted without pointer reset");

    a_done_quiet: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (st.phase == result_seq_pkg::PH_DONE) |-> !push)
        else $error("word produced after sequence end");

    a_ptr_load: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ce_i && ptr_rst_i) |=> (st.seq_ptr == $past(start_seq_i))
            && (st.sub_ptr == $past(start_sub_i)))
        else $error("pointer reset did not load start numbers");

    a_status_raw: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (push && !sub_now && src == result_seq_pkg::SRC_HIT_STATUS)
            |-> (push_word == hit_status_i))
        else $error("hit status word was mixed");

    a_hit_pulse: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (st.next_hit && $past(ce_i)) |-> $past(rd_fall))
        else $error("hit advance without a strobe");

    a_fifo_room: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        push |-> fifo_ready)
        else $error("result word pushed into a full buffer");
endmodule : search_result_output_sequencer
`default_nettype wire

// File: dv/host_strobe_model.sv
// host model: issues one active-low read strobe per request
`default_nettype none
module host_strobe_model (
    input  wire logic sys_clk_i, // clock
    input  wire logic go_i,      // request one strobe
    output logic      rd_n_o     // read strobe, active low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt = 2'h0;
    // strobe held low three cycles so the falling edge is one clean event
    assign rd_n_o = (cnt == 2'h0);
    always @(posedge sys_clk_i) begin
        if (go_i) cnt <= 2'h3;
        else if (cnt != 2'h0) cnt <= cnt - 2'h1;
    end
endmodule : host_strobe_model
`default_nettype wire

// File: dv/tb.sv
// testbench: programs steps, strobes the sequencer and checks the result bus
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, go = 0, rd_n, prst = 0, csel = 1, vld, done;
    logic rsub = 0, seen, ce = 1, mh = 0, hon;
    logic [2:0] sseq = 3'h0, ssub = 3'h0, ridx = 3'h0, ksel, ptr;
    logic [15:0] rdata, ha = 16'h0005;
    logic [31:0] bus, got = 32'h0, key = 32'h1234_5678, hs = 32'h0000_00c3;
    result_seq_pkg::cfg_wr_t cfg = '0;
    result_seq_pkg::status_bits_t st = 10'h2a5;
    int n_errors = 0, checks = 0, cyc = 0;
    host_strobe_model host (.sys_clk_i(sys_clk), .go_i(go), .rd_n_o(rd_n));
    search_result_output_sequencer uut (.sys_clk_i(sys_clk), .rst_i(rst),
        .ce_i(ce), .rd_n_i(rd_n), .ptr_rst_i(prst), .chan_sel_i(csel),
        .start_seq_i(sseq), .start_sub_i(ssub), .cfg_i(cfg),
        .cfg_rd_sub_i(rsub), .cfg_rd_idx_i(ridx), .cfg_rd_data_o(rdata),
        .hit_addr_i(ha), .more_hits_i(mh), .any_hit_i(1'b1),
        .contents_i(32'h0), .key_i(key), .hit_status_i(hs), .status_i(st),
        .key_sel_o(ksel), .segment_o(), .next_hit_o(), .hit_out_n_o(hon),
        .multi_hit_out_n_o(), .seq_ptr_o(ptr), .seq_done_o(done),
        .result_bus_o(bus), .result_valid_o(vld), .result_ready_i(1'b1));
    initial forever #12.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic s, input logic [2:0] i, input logic [15:0] d);
        @(negedge sys_clk) cfg = '{1'b1, s, i, d};
        @(negedge sys_clk) cfg.we = 1'b0;
    endtask : wr
    // waits a fixed window and keeps only the first word seen in it; a second word is not detected
    task automatic strobe();
        @(negedge sys_clk) go = 1'b1;
        @(negedge sys_clk) go = 1'b0;
        seen = 1'b0;
        repeat (20) begin
            @(negedge sys_clk);
            if (vld === 1'b1 && !seen) begin
                seen = 1'b1;
                got = bus;
            end
        end
    endtask : strobe
    task automatic restart(input logic [2:0] s);
        @(negedge sys_clk) begin csel = 1'b1; sseq = s; prst = 1'b1; end
        @(negedge sys_clk) prst = 1'b0;
        @(negedge sys_clk) chk({29'h0, ptr}, {29'h0, s});
    endtask : restart
    task automatic t_cfg();
        wr(1'b0, 3'h0, 16'h0c90);
        wr(1'b0, 3'h1, 16'h0fa2);
        wr(1'b1, 3'h0, 16'h0800);
        wr(1'b0, 3'h2, 16'h0894);
        @(negedge sys_clk) ridx = 3'h1;
        @(negedge sys_clk) chk({16'h0, rdata}, 32'h0fa2);
    endtask : t_cfg
    task automatic t_status();
        restart(3'h0);
        strobe();
        chk({31'h0, seen}, 32'h1);
        chk(got, hs);
        chk({31'h0, done}, 32'h1);
        strobe();
        chk({31'h0, seen}, 32'h0);
    endtask : t_status
    task automatic t_key();
        restart(3'h1);
        strobe();
        chk({29'h0, ksel}, 32'h1);
        chk(got, {st.hit, st.och, st.ich, key[21:0]});
    endtask : t_key
    task automatic t_hits();
        restart(3'h2);
        chk({31'h0, hon}, 32'h0);
        mh = 1'b1;
        strobe();
        chk(got, {16'h0, ha});
        chk({29'h0, ptr}, 32'h2);
        mh = 1'b0;
        strobe();
        chk(got, {16'h0, ha});
        chk({30'h0, done, hon}, 32'h3);
    endtask : t_hits
    task automatic close_out();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        t_cfg();
        t_status();
        t_key();
        t_hits();
        close_out();
    end
endmodule : tb
`default_nettype wire
